// ===== common/nvac_consts.vh
// constants for the nonvolatile byte access controller
`ifndef NVAC_CONSTS_VH
`define NVAC_CONSTS_VH

// byte offsets on the register bus
`define NVAC_OFS_DATA      5'h00
`define NVAC_OFS_ADDR      5'h04
`define NVAC_OFS_CTRL      5'h08
`define NVAC_OFS_UNLOCK    5'h0c
`define NVAC_OFS_FLAGS     5'h10

// control register field positions
`define NVAC_CTRL_RD       0
`define NVAC_CTRL_WR       1
`define NVAC_CTRL_PERMIT   2
`define NVAC_CTRL_ABORT    3

// peripheral flag register field position
`define NVAC_FLAGS_DONE    7

// reset values
`define NVAC_DATA_RST      8'h00
`define NVAC_ADDR_RST      8'h00

// unlock keys
`define NVAC_KEY_FIRST     8'h55
`define NVAC_KEY_SECOND    8'haa

// timing
`define NVAC_CLK_NS        8
`define NVAC_PWRT_MS       64
`define NVAC_PWRT_CYCLES   ((`NVAC_PWRT_MS * 1000000) / `NVAC_CLK_NS)
`define NVAC_WRITE_CYCLES  16'h03e8
`define NVAC_UNLOCK_WINDOW 4'h8

// array size: 8 for 256 bytes, 7 for 128 bytes
`define NVAC_ADDR_BITS     8

`endif

// ===== design/nvac_array.v
// byte array storage with erase and program strobes and programmer read port
module nvac_array #(
  parameter ADDR_BITS = 8
) (
  input  wire                 core_clk,
  input  wire                 sys_rst,
  input  wire                 erase_stb,
  input  wire                 prog_stb,
  input  wire [ADDR_BITS-1:0] wr_addr,
  input  wire [7:0]           wr_data,
  input  wire [ADDR_BITS-1:0] rd_addr,
  output wire [7:0]           rd_data,
  input  wire [ADDR_BITS-1:0] prog_addr,
  input  wire                 code_protect,
  output wire [7:0]           prog_rdata
);
  localparam DEPTH = 1 << ADDR_BITS;

  reg [7:0] mem [0:DEPTH-1];
  reg [7:0] prog_rdata_r;

  // erase first, then program the same location
  always @(posedge core_clk) begin
    if (erase_stb) begin
      mem[wr_addr] <= 8'hff;
    end else if (prog_stb) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

  // external programmer sees zeros under protection
  always @(posedge core_clk) begin
    if (sys_rst) begin
      prog_rdata_r <= 8'h00;
    end else if (code_protect) begin
      prog_rdata_r <= 8'h00;
    end else begin
      prog_rdata_r <= mem[prog_addr];
    end
  end

  assign prog_rdata = prog_rdata_r;

endmodule // nvac_array

// ===== design/nvac_ctrl.v
// register front end, unlock sequencer and write timer for the byte array
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`include "nvac_consts.vh"

module nvac_ctrl #(
  parameter        ADDR_BITS    = `NVAC_ADDR_BITS,
  parameter [23:0] PWRT_CYCLES  = `NVAC_PWRT_CYCLES,
  parameter [15:0] WRITE_CYCLES = `NVAC_WRITE_CYCLES
) (
  input  wire                 core_clk,
  input  wire                 sys_rst,
  input  wire [4:0]           avs_address,
  input  wire                 avs_read,
  input  wire                 avs_write,
  input  wire [31:0]          avs_writedata,
  input  wire [3:0]           avs_byteenable,
  output wire [31:0]          avs_readdata,
  output wire                 avs_waitrequest,
  input  wire                 external_reset_pin_n,
  input  wire                 watchdog_timer_rst,
  input  wire                 brownout_reset,
  input  wire                 code_protect,
  input  wire [ADDR_BITS-1:0] prog_addr,
  output wire [7:0]           prog_rdata,
  output wire                 write_done_flag,
  output wire                 nv_write_busy
);
  localparam [2:0] U_IDLE = 3'b001;
  localparam [2:0] U_KEY1 = 3'b010;
  localparam [2:0] U_KEY2 = 3'b100;
  localparam [7:0] ADDR_MASK = (ADDR_BITS == 8) ? 8'hff : 8'h7f;

  function hit;
    input [4:0] addr;
    input [4:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  function [31:0] pad32;
    input [7:0] val;
    begin
      pad32 = {24'h000000, val};
    end
  endfunction

  reg  [2:0]           rst_s1_r;
  reg  [2:0]           rst_s2_r;
  reg                  ack_r;
  reg  [31:0]          rdata_r;
  reg  [31:0]          rmux;
  reg  [7:0]           data_r;
  reg  [7:0]           addr_r;
  reg                  rd_trig_r;
  reg                  wr_trig_r;
  reg                  permit_r;
  reg                  abort_r;
  reg                  done_r;
  reg  [2:0]           ustate_r;
  reg  [2:0]           ustate_nxt;
  reg  [3:0]           ugap_r;
  reg  [23:0]          pwrt_cnt_r;
  reg  [15:0]          wtmr_r;
  reg  [ADDR_BITS-1:0] lat_addr_r;
  reg  [7:0]           lat_data_r;
  reg                  erase_stb_r;
  reg                  prog_stb_r;
  wire [7:0]           arr_rdata;
  wire                 warm_rst;
  wire                 req;
  wire                 wr_acc;
  wire                 rd_acc;
  wire                 be0;
  wire                 data_wr;
  wire                 addr_wr;
  wire                 ctrl_wr;
  wire                 unlock_wr;
  wire                 flags_wr;
  wire                 key1;
  wire                 key2;
  wire                 gap_out;
  wire                 pwrt_busy;
  wire                 wr_start;
  wire                 done_set;
  wire                 abort_set;

  // two-stage synchronisers for the warm reset sources
  always @(posedge core_clk) begin
    if (sys_rst) begin
      rst_s1_r <= 3'h0;
      rst_s2_r <= 3'h0;
    end else begin
      rst_s1_r <= {~external_reset_pin_n, watchdog_timer_rst, brownout_reset};
      rst_s2_r <= rst_s1_r;
    end
  end

  assign warm_rst = |rst_s2_r;

  // bus slave with one wait state per access
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_acc          = avs_write & ack_r;
  assign rd_acc          = avs_read & ack_r;
  assign be0             = avs_byteenable[0];

  always @(posedge core_clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  assign data_wr   = wr_acc & be0 & hit(avs_address, `NVAC_OFS_DATA);
  assign addr_wr   = wr_acc & be0 & hit(avs_address, `NVAC_OFS_ADDR);
  assign ctrl_wr   = wr_acc & be0 & hit(avs_address, `NVAC_OFS_CTRL);
  assign unlock_wr = wr_acc & be0 & hit(avs_address, `NVAC_OFS_UNLOCK);
  assign flags_wr  = wr_acc & be0 & hit(avs_address, `NVAC_OFS_FLAGS);
  assign key1      = avs_writedata[7:0] == `NVAC_KEY_FIRST;
  assign key2      = avs_writedata[7:0] == `NVAC_KEY_SECOND;

  // read mux, unmapped offsets read zero
  always @* begin
    rmux = 32'h00000000;
    case (avs_address)
      `NVAC_OFS_DATA: begin
        rmux = pad32(data_r);
      end
      `NVAC_OFS_ADDR: begin
        rmux = pad32(addr_r & ADDR_MASK);
      end
      `NVAC_OFS_CTRL: begin
        rmux = pad32({4'h0, abort_r, permit_r, wr_trig_r, rd_trig_r});
      end
      `NVAC_OFS_UNLOCK: begin
        rmux = 32'h00000000;
      end
      `NVAC_OFS_FLAGS: begin
        rmux = pad32({done_r, 7'h00});
      end
      default: begin
        rmux = 32'h00000000;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h00000000;
    end else if (avs_read & ~ack_r) begin
      rdata_r <= rmux;
    end
  end

  assign avs_readdata = rdata_r;

  // power-up timer
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pwrt_cnt_r <= PWRT_CYCLES;
    end else if (pwrt_cnt_r != 24'h000000) begin
      pwrt_cnt_r <= pwrt_cnt_r - 24'h000001;
    end
  end

  assign pwrt_busy = pwrt_cnt_r != 24'h000000;

  // unlock sequencer
  assign gap_out = (ustate_r != U_IDLE) & (ugap_r == `NVAC_UNLOCK_WINDOW);

  always @* begin
    ustate_nxt = ustate_r;
    case (ustate_r)
      U_IDLE: begin
        if (unlock_wr & key1) begin
          ustate_nxt = U_KEY1;
        end
      end
      U_KEY1: begin
        if (unlock_wr & key2) begin
          ustate_nxt = U_KEY2;
        end else if (unlock_wr & key1) begin
          ustate_nxt = U_KEY1;
        end else if (wr_acc | rd_acc | gap_out) begin
          ustate_nxt = U_IDLE;
        end
      end
      U_KEY2: begin
        if (unlock_wr & key1) begin
          ustate_nxt = U_KEY1;
        end else if (wr_acc | rd_acc | gap_out) begin
          ustate_nxt = U_IDLE;
        end
      end
      default: begin
        ustate_nxt = U_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst | warm_rst) begin
      ustate_r <= U_IDLE;
      ugap_r   <= 4'h0;
    end else begin
      ustate_r <= ustate_nxt;
      if (wr_acc | rd_acc) begin
        ugap_r <= 4'h0;
      end else if (ustate_r != U_IDLE && ugap_r != `NVAC_UNLOCK_WINDOW) begin
        ugap_r <= ugap_r + 4'h1;
      end
    end
  end

  // write start qualification
  assign wr_start = ctrl_wr & avs_writedata[`NVAC_CTRL_WR] & ~wr_trig_r
                  & permit_r & (ustate_r == U_KEY2) & ~gap_out
                  & ~pwrt_busy & ~warm_rst;
  assign done_set  = wr_trig_r & (wtmr_r == 16'h0000) & ~warm_rst;
  assign abort_set = warm_rst & wr_trig_r;

  // write timer and array strobes
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wr_trig_r   <= 1'b0;
      wtmr_r      <= 16'h0000;
      lat_addr_r  <= {ADDR_BITS{1'b0}};
      lat_data_r  <= 8'h00;
      erase_stb_r <= 1'b0;
      prog_stb_r  <= 1'b0;
    end else begin
      erase_stb_r <= 1'b0;
      prog_stb_r  <= 1'b0;
      if (warm_rst) begin
        wr_trig_r <= 1'b0;
      end else if (wr_start) begin
        wr_trig_r   <= 1'b1;
        wtmr_r      <= WRITE_CYCLES - 16'h0001;
        lat_addr_r  <= addr_r[ADDR_BITS-1:0];
        lat_data_r  <= data_r;
        erase_stb_r <= 1'b1;
      end else if (wr_trig_r) begin
        if (wtmr_r == 16'h0000) begin
          wr_trig_r  <= 1'b0;
          prog_stb_r <= 1'b1;
        end else begin
          wtmr_r <= wtmr_r - 16'h0001;
        end
      end
    end
  end

  // control flags
  always @(posedge core_clk) begin
    if (sys_rst) begin
      rd_trig_r <= 1'b0;
      permit_r  <= 1'b0;
      abort_r   <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      if (warm_rst) begin
        rd_trig_r <= 1'b0;
      end else if (rd_trig_r) begin
        rd_trig_r <= 1'b0;
      end else if (ctrl_wr & avs_writedata[`NVAC_CTRL_RD]) begin
        rd_trig_r <= 1'b1;
      end
      if (ctrl_wr) begin
        permit_r <= avs_writedata[`NVAC_CTRL_PERMIT];
      end
      if (abort_set) begin
        abort_r <= 1'b1;
      end else if (ctrl_wr) begin
        abort_r <= avs_writedata[`NVAC_CTRL_ABORT];
      end
      if (done_set) begin
        done_r <= 1'b1;
      end else if (flags_wr) begin
        done_r <= avs_writedata[`NVAC_FLAGS_DONE];
      end
    end
  end

  // data and address registers
  always @(posedge core_clk) begin
    if (sys_rst | warm_rst) begin
      data_r <= `NVAC_DATA_RST;
      addr_r <= `NVAC_ADDR_RST;
    end else begin
      if (rd_trig_r) begin
        data_r <= arr_rdata;
      end else if (data_wr) begin
        data_r <= avs_writedata[7:0];
      end
      if (addr_wr) begin
        addr_r <= avs_writedata[7:0] & ADDR_MASK;
      end
    end
  end

  nvac_array #(
    .ADDR_BITS (ADDR_BITS)
  ) u_array (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .erase_stb    (erase_stb_r),
    .prog_stb     (prog_stb_r),
    .wr_addr      (lat_addr_r),
    .wr_data      (lat_data_r),
    .rd_addr      (addr_r[ADDR_BITS-1:0]),
    .rd_data      (arr_rdata),
    .prog_addr    (prog_addr),
    .code_protect (code_protect),
    .prog_rdata   (prog_rdata)
  );

  assign write_done_flag = done_r;
  assign nv_write_busy   = wr_trig_r;

endmodule // nvac_ctrl

// ===== sim/nvac_ctrl_asserts.sv
// port assertions for the byte access controller
`include "nvac_consts.vh"
module nvac_chk #(
  parameter [15:0] WRITE_CYCLES = 16'h03e8
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        brownout_reset,
  input wire logic        code_protect,
  input wire logic [7:0]  prog_rdata,
  input wire logic        write_done_flag,
  input wire logic        nv_write_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic [15:0] busy_cnt_r;
  wire         acc_w = avs_write & ~avs_waitrequest;
  wire         acc_r = avs_read & ~avs_waitrequest;
  wire         go_w  = acc_w & avs_byteenable[0] & avs_writedata[1]
                       & (avs_address == `NVAC_OFS_CTRL);
  // cycles the write trigger has stood
  always @(posedge core_clk) begin
    if (sys_rst || !nv_write_busy)
      busy_cnt_r <= 16'h0000;
    else
      busy_cnt_r <= busy_cnt_r + 16'h0001;
  end
  property p_busy_len;
    $rose(write_done_flag) |-> $fell(nv_write_busy) && busy_cnt_r == WRITE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write time wrong");
  property p_done_hold;
    write_done_flag && !(acc_w && avs_address == `NVAC_OFS_FLAGS) |=> write_done_flag;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag lost");
  property p_start;
    $rose(nv_write_busy) |-> $past(go_w);
  endproperty
  a_start: assert property (p_start) else $error("write without start");
  property p_unlock_zero;
    acc_r && avs_address == `NVAC_OFS_UNLOCK |-> avs_readdata == 32'h00000000;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock not zero");
  property p_ctrl_upper;
    acc_r && avs_address == `NVAC_OFS_CTRL |-> avs_readdata[31:4] == 28'h0000000;
  endproperty
  a_ctrl_upper: assert property (p_ctrl_upper) else $error("ctrl upper set");
  property p_prog_zero;
    code_protect |=> prog_rdata == 8'h00;
  endproperty
  a_prog_zero: assert property (p_prog_zero) else $error("programmer sees data");
  property p_wait_one;
    $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  property p_abort_stop;
    brownout_reset |-> ##[1:4] !nv_write_busy;
  endproperty
  a_abort_stop: assert property (p_abort_stop) else $error("write not aborted");
endmodule // nvac_chk

bind nvac_ctrl nvac_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.*);

// ===== sim/nvac_cpu.sv
// bus master standing in for software on the core
`include "nvac_consts.vh"
module nvac_cpu (
  input  wire logic        core_clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        nv_write_busy,
  output logic [4:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  output logic             hang
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {avs_address, avs_read, avs_write} = 7'h00;
    {avs_writedata, avs_byteenable, hang} = 37'h0;
  end
  // one access, held until waitrequest is seen low
  task automatic acc(input bit w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (avs_waitrequest !== 1'b0)
      hang <= 1'b1;
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~avs_writedata;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, 4'h1, q);
  endtask
  // unlock and start one byte; pm and gap allow broken sequences
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic [7:0] k2,
                     input logic [7:0] pm, input int gap);
    wr(`NVAC_OFS_ADDR, a);
    wr(`NVAC_OFS_DATA, d);
    wr(`NVAC_OFS_CTRL, pm);
    wr(`NVAC_OFS_UNLOCK, 8'h55);
    repeat (gap) @(posedge core_clk);
    wr(`NVAC_OFS_UNLOCK, k2);
    wr(`NVAC_OFS_CTRL, pm | 8'h02);
  endtask
  // wait out the write, then drop the permit
  task automatic settle;
    int n;
    n = 0;
    while (nv_write_busy !== 1'b0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (nv_write_busy !== 1'b0)
      hang <= 1'b1;
    wr(`NVAC_OFS_CTRL, 8'h00);
  endtask
endmodule // nvac_cpu

// ===== sim/testbench.sv
// self-checking bench for the byte access controller
`include "nvac_consts.vh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        external_reset_pin_n = 1'b1;
  logic        watchdog_timer_rst = 1'b0;
  logic        brownout_reset = 1'b0;
  logic        code_protect = 1'b0;
  logic [7:0]  prog_addr = 8'h00;
  logic [4:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, write_done_flag, nv_write_busy, hang;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [7:0]  prog_rdata;
  logic [31:0] avs_readdata_small;
  logic [7:0]  prog_rdata_small;
  int          n_errors = 0;
  int          n_compared = 0;
  nvac_ctrl #(.ADDR_BITS(8), .PWRT_CYCLES(24'h000028), .WRITE_CYCLES(16'h000a)) dut (.*);
  // 128-byte variant on the same bus, only its read data is watched
  nvac_ctrl #(.ADDR_BITS(7), .PWRT_CYCLES(24'h000028), .WRITE_CYCLES(16'h000a)) dut_small (
    .core_clk             (core_clk),
    .sys_rst              (sys_rst),
    .avs_address          (avs_address),
    .avs_read             (avs_read),
    .avs_write            (avs_write),
    .avs_writedata        (avs_writedata),
    .avs_byteenable       (avs_byteenable),
    .avs_readdata         (avs_readdata_small),
    .avs_waitrequest      (),
    .external_reset_pin_n (external_reset_pin_n),
    .watchdog_timer_rst   (watchdog_timer_rst),
    .brownout_reset       (brownout_reset),
    .code_protect         (code_protect),
    .prog_addr            (prog_addr[6:0]),
    .prog_rdata           (prog_rdata_small),
    .write_done_flag      (),
    .nv_write_busy        ()
  );
  nvac_cpu cpu (.*);
  always #4 core_clk = ~core_clk;
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] ex, input string nm);
    logic [7:0] q;
    cpu.acc(1'b0, a, 8'h00, 4'h1, q);
    `CHK(nm, ex, q)
  endtask
  task automatic t_powerup;
    cpu.put(8'h10, 8'h3c, 8'haa, 8'h04, 0);
    `CHK("busy", 1'b0, nv_write_busy)
    rd(`NVAC_OFS_CTRL, 8'h04, "ctrl");
    repeat (40) @(posedge core_clk);
  endtask
  task automatic t_regs;
    logic [7:0] q;
    cpu.wr(`NVAC_OFS_CTRL, 8'hf4);
    rd(`NVAC_OFS_CTRL, 8'h04, "ctrl");
    rd(`NVAC_OFS_UNLOCK, 8'h00, "unlock");
    rd(5'h14, 8'h00, "unmapped");
    cpu.acc(1'b1, `NVAC_OFS_ADDR, 8'h99, 4'h0, q);
    rd(`NVAC_OFS_ADDR, 8'h10, "addr");
  endtask
  task automatic t_write_read;
    logic [7:0] v [2] = '{8'ha5, 8'h5a};
    for (int i = 0; i < 2; i++) begin
      cpu.put(8'hff, v[i], 8'haa, 8'h04, 0);
      `CHK("busy", 1'b1, nv_write_busy)
      cpu.settle();
      rd(`NVAC_OFS_FLAGS, 8'h80, "done");
      cpu.wr(`NVAC_OFS_FLAGS, 8'h00);
      rd(`NVAC_OFS_FLAGS, 8'h00, "done");
      cpu.wr(`NVAC_OFS_DATA, 8'h00);
      cpu.wr(`NVAC_OFS_CTRL, 8'h01);
      rd(`NVAC_OFS_DATA, v[i], "rdback");
      rd(`NVAC_OFS_CTRL, 8'h00, "ctrl");
      rd(`NVAC_OFS_DATA, v[i], "hold");
    end
  endtask
  task automatic t_bad;
    logic [7:0] k [3] = '{8'h55, 8'haa, 8'haa};
    logic [7:0] p [3] = '{8'h04, 8'h00, 8'h04};
    int         g [3] = '{0, 0, 10};
    for (int i = 0; i < 3; i++) begin
      cpu.put(8'h30, 8'h11, k[i], p[i], g[i]);
      `CHK("busy", 1'b0, nv_write_busy)
      rd(`NVAC_OFS_CTRL, p[i], "ctrl");
    end
  endtask
  task automatic t_abort;
    for (int i = 0; i < 3; i++) begin
      cpu.put(8'h20, 8'h77, 8'haa, 8'h04, 0);
      repeat (3) @(posedge core_clk);
      external_reset_pin_n <= (i != 0);
      watchdog_timer_rst <= (i == 1);
      brownout_reset <= (i == 2);
      repeat (3) @(posedge core_clk);
      external_reset_pin_n <= 1'b1;
      watchdog_timer_rst <= 1'b0;
      brownout_reset <= 1'b0;
      repeat (4) @(posedge core_clk);
      `CHK("busy", 1'b0, nv_write_busy)
      `CHK("done", 1'b0, write_done_flag)
      rd(`NVAC_OFS_CTRL, 8'h0c, "ctrl");
      rd(`NVAC_OFS_DATA, 8'h00, "data");
      rd(`NVAC_OFS_ADDR, 8'h00, "addr");
      cpu.settle();
    end
  endtask
  task automatic t_protect;
    prog_addr <= 8'hff;
    repeat (2) @(posedge core_clk);
    `CHK("prog", 8'h5a, prog_rdata)
    code_protect <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK("prog", 8'h00, prog_rdata)
    cpu.wr(`NVAC_OFS_ADDR, 8'hff);
    rd(`NVAC_OFS_ADDR, 8'hff, "addr");
    `CHK("addr_small", 8'h7f, avs_readdata_small[7:0])
    cpu.wr(`NVAC_OFS_CTRL, 8'h01);
    rd(`NVAC_OFS_DATA, 8'h5a, "cpu");
    `CHK("data_small", 8'h5a, avs_readdata_small[7:0])
    code_protect <= 1'b0;
  endtask
  always @(posedge hang) begin
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_powerup();
    t_regs();
    t_write_read();
    t_bad();
    t_abort();
    t_protect();
    give_verdict();
  end
endmodule // testbench
